// *** hdl/port_bit_rmw_access.sv ***
// Local design decisions: the register offsets and the Wishbone slave port.
`include "pbr_regs.svh"
module port_bit_rmw_access (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port pins.
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  output logic [7:0] pullUpOn
);
  import pbr_pkg::*;

  // ========================================================================
  // Instruction decode
  // ========================================================================
  // Op word: [31:24] opcode class, [23:16] second byte, [15:8] abs/reg
  // byte, [7:0] second word low byte.
  function automatic pbr_op_e opOf(input logic [3:0] code);
    return (code <= 4'hd) ? pbr_op_e'(code) : PBR_OP_BAD;
  endfunction : opOf

  function automatic logic regBitAllowed(input pbr_op_e op);
    return (op == PBR_OP_SET) || (op == PBR_OP_CLR) ||
           (op == PBR_OP_NOT) || (op == PBR_OP_TST);
  endfunction : regBitAllowed

  function automatic logic isWriteBack(input pbr_op_e op);
    return (op == PBR_OP_SET) || (op == PBR_OP_CLR) ||
           (op == PBR_OP_NOT) || (op == PBR_OP_ST) || (op == PBR_OP_IST);
  endfunction : isWriteBack

  // ========================================================================
  // Pin synchroniser
  // ========================================================================
  logic [7:0] pinSync;
  pbr_sync #(.WIDTH(8)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .rawIn(pinIn),
    .cleanOut(pinSync)
  );

  // ========================================================================
  // State
  // ========================================================================
  typedef enum logic [1:0] {
    PBR_S_IDLE, PBR_S_READ, PBR_S_MODIFY, PBR_S_WRITE
  } pbr_state_e;

  pbr_state_e state_q, state_d;
  logic [7:0] dir_q, dir_d;
  logic [7:0] data_q, data_d;
  logic [7:0] greg_q, greg_d;
  logic [7:0] byte_q, byte_d;
  logic [2:0] bitNo_q, bitNo_d;
  pbr_op_e op_q, op_d;
  pbr_target_e tgt_q, tgt_d;
  logic carry_q, carry_d;
  logic zero_q, zero_d;
  logic ill_q, ill_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0] pinOut_q, pinOe_q, pull_q;
  logic [7:0] portRead;
  logic [7:0] opWord;
  logic [7:0] modByte;
  logic selBit;
  logic req;

  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign portRead = (pinSync & ~dir_q) | (data_q & dir_q);

  // Decode of a command write: class, bit source, operand mode.
  pbr_op_e dOp;
  logic dRegBit;
  logic [1:0] dMode;
  logic [2:0] dBit;
  logic dIll;
  pbr_target_e dTgt;
  always_comb begin
    dOp = opOf(wb_dat_i[27:24]);
    dRegBit = wb_dat_i[28];
    dMode = wb_dat_i[30:29];
    dBit = dRegBit ? greg_q[2:0] : wb_dat_i[22:20];
    dIll = (dOp == PBR_OP_BAD) || (dRegBit && !regBitAllowed(dOp));
    dTgt = PBR_T_NONE;
    unique case (dMode)
      2'd0: dTgt = PBR_T_REG;
      2'd1, 2'd2: begin
        // Indirect and absolute forms: second word low nibble must be zero.
        if (wb_dat_i[3:0] != 4'h0) begin
          dIll = 1'b1;
        end
        if (wb_dat_i[15:8] == 8'h00) begin
          dTgt = PBR_T_DIR;
        end else if (wb_dat_i[15:8] == 8'h01) begin
          dTgt = PBR_T_DATA;
        end else begin
          dTgt = PBR_T_NONE;
        end
      end
      default: dIll = 1'b1;
    endcase
  end

  // ========================================================================
  // Modify step
  // ========================================================================
  always_comb begin
    selBit = byte_q[bitNo_q];
    modByte = byte_q;
    unique case (op_q)
      PBR_OP_SET: modByte[bitNo_q] = 1'b1;
      PBR_OP_CLR: modByte[bitNo_q] = 1'b0;
      PBR_OP_NOT: modByte[bitNo_q] = ~selBit;
      PBR_OP_ST: modByte[bitNo_q] = carry_q;
      PBR_OP_IST: modByte[bitNo_q] = ~carry_q;
      default: modByte = byte_q;
    endcase
  end

  always_comb begin
    state_d = state_q;
    dir_d = dir_q;
    data_d = data_q;
    greg_d = greg_q;
    byte_d = byte_q;
    bitNo_d = bitNo_q;
    op_d = op_q;
    tgt_d = tgt_q;
    carry_d = carry_q;
    zero_d = zero_q;
    ill_d = ill_q;
    ack_d = 1'b0;
    rdat_d = rdat_q;
    opWord = 8'h00;
    // A command is accepted only while idle; otherwise bus waits.
    if (req && (state_q == PBR_S_IDLE || wb_adr_i[4:0] != `PBR_OFS_OP)) begin
      ack_d = 1'b1;
      rdat_d = 32'h0000_0000;
      unique case (wb_adr_i[4:0])
        `PBR_OFS_DIR: begin
          rdat_d[7:0] = `PBR_DIR_READ;
          if (wb_we_i && wb_sel_i[0]) begin
            dir_d = wb_dat_i[7:0];
          end
        end
        `PBR_OFS_DATA: begin
          rdat_d[7:0] = portRead;
          if (wb_we_i && wb_sel_i[0]) begin
            data_d = wb_dat_i[7:0];
          end
        end
        `PBR_OFS_OP: begin
          if (wb_we_i && (&wb_sel_i)) begin
            op_d = dOp;
            bitNo_d = dBit;
            tgt_d = dTgt;
            ill_d = dIll;
            state_d = dIll ? PBR_S_IDLE : PBR_S_READ;
          end
        end
        `PBR_OFS_STAT: begin
          rdat_d[`PBR_STAT_BUSY] = (state_q != PBR_S_IDLE);
          rdat_d[`PBR_STAT_ILL] = ill_q;
          rdat_d[`PBR_STAT_CARRY] = carry_q;
          rdat_d[`PBR_STAT_ZERO] = zero_q;
          if (wb_we_i && wb_sel_i[0]) begin
            carry_d = wb_dat_i[`PBR_STAT_CARRY];
          end
        end
        `PBR_OFS_GREG: begin
          rdat_d[7:0] = greg_q;
          if (wb_we_i && wb_sel_i[0]) begin
            greg_d = wb_dat_i[7:0];
          end
        end
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    unique case (state_q)
      PBR_S_IDLE: ;
      PBR_S_READ: begin
        // Whole byte is read as software would see it.
        unique case (tgt_q)
          PBR_T_REG: opWord = greg_q;
          PBR_T_DIR: opWord = `PBR_DIR_READ;
          PBR_T_DATA: opWord = portRead;
          default: opWord = 8'h00;
        endcase
        byte_d = opWord;
        state_d = PBR_S_MODIFY;
      end
      PBR_S_MODIFY: begin
        unique case (op_q)
          PBR_OP_TST: zero_d = ~selBit;
          PBR_OP_AND: carry_d = carry_q & selBit;
          PBR_OP_OR: carry_d = carry_q | selBit;
          PBR_OP_XOR: carry_d = carry_q ^ selBit;
          PBR_OP_LD: carry_d = selBit;
          PBR_OP_IAND: carry_d = carry_q & ~selBit;
          PBR_OP_IOR: carry_d = carry_q | ~selBit;
          PBR_OP_IXOR: carry_d = carry_q ^ ~selBit;
          PBR_OP_ILD: carry_d = ~selBit;
          default: ;
        endcase
        byte_d = modByte;
        state_d = isWriteBack(op_q) ? PBR_S_WRITE : PBR_S_IDLE;
      end
      PBR_S_WRITE: begin
        // All eight bits go back, so bits read as ones stay ones, except the modified bit.
        unique case (tgt_q)
          PBR_T_REG: greg_d = byte_q;
          PBR_T_DIR: dir_d = byte_q;
          PBR_T_DATA: data_d = byte_q;
          default: ;
        endcase
        state_d = PBR_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PBR_S_IDLE;
      dir_q <= `PBR_RST_DIR;
      data_q <= `PBR_RST_DATA;
      greg_q <= 8'h00;
      byte_q <= 8'h00;
      bitNo_q <= 3'h0;
      op_q <= PBR_OP_SET;
      tgt_q <= PBR_T_NONE;
      carry_q <= 1'b0;
      zero_q <= 1'b0;
      ill_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      pinOut_q <= 8'h00;
      pinOe_q <= 8'h00;
      pull_q <= 8'h00;
    end else begin
      state_q <= state_d;
      dir_q <= dir_d;
      data_q <= data_d;
      greg_q <= greg_d;
      byte_q <= byte_d;
      bitNo_q <= bitNo_d;
      op_q <= op_d;
      tgt_q <= tgt_d;
      carry_q <= carry_d;
      zero_q <= zero_d;
      ill_q <= ill_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      pinOut_q <= dir_q & data_q;
      pinOe_q <= dir_q;
      pull_q <= ~dir_q & data_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign pinOut = pinOut_q;
  assign pinOe = pinOe_q;
  assign pullUpOn = pull_q;

  // ========================================================================
  // Checks
  // ========================================================================
  property p_dir_read;
    @(posedge clk) disable iff (!reset_n)
    (req && !wb_we_i && wb_adr_i == `PBR_OFS_DIR) |=>
      (wb_ack_o && wb_dat_o == 32'h0000_00ff);
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction read not all ones");
  property p_oe;
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> (pinOe == $past(dir_q));
  endproperty
  a_oe: assert property (p_oe)
    else $error("output enable does not follow direction");
  property p_data_read;
    @(posedge clk) disable iff (!reset_n)
    (req && !wb_we_i && wb_adr_i == `PBR_OFS_DATA) |=>
      (wb_dat_o[7:0] == (($past(pinSync) & ~$past(dir_q)) |
                         ($past(data_q) & $past(dir_q))));
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data read mixes pins and latch wrongly");
  property p_pull;
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> (pullUpOn == ($past(data_q) & ~$past(dir_q)));
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull-up does not follow input data bits");
  property p_seq;
    @(posedge clk) disable iff (!reset_n)
    (state_q == PBR_S_READ) |=> (state_q == PBR_S_MODIFY);
  endproperty
  a_seq: assert property (p_seq)
    else $error("read step not followed by modify");
  property p_dir_wb;
    @(posedge clk) disable iff (!reset_n)
    (state_q == PBR_S_READ && tgt_q == PBR_T_DIR && op_q == PBR_OP_CLR)
      |=> ##1 ##1 (dir_q == ~(8'h01 << $past(bitNo_q, 3)));
  endproperty
  a_dir_wb: assert property (p_dir_wb)
    else $error("direction write-back not all ones but cleared bit");
  property p_regbit;
    @(posedge clk) disable iff (!reset_n)
    (req && wb_we_i && wb_adr_i == `PBR_OFS_OP && &wb_sel_i &&
     state_q == PBR_S_IDLE && wb_dat_i[28] && !regBitAllowed(dOp))
      |=> (ill_q && state_q == PBR_S_IDLE);
  endproperty
  a_regbit: assert property (p_regbit)
    else $error("register bit number accepted for immediate-only op");
  property p_nibble;
    @(posedge clk) disable iff (!reset_n)
    (req && wb_we_i && wb_adr_i == `PBR_OFS_OP && &wb_sel_i &&
     state_q == PBR_S_IDLE && wb_dat_i[30:29] != 2'd0 &&
     wb_dat_i[3:0] != 4'h0) |=> ill_q;
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("nonzero low nibble accepted");
endmodule : port_bit_rmw_access

// *** hdl/pbr_regs.svh ***
`ifndef PBR_REGS_SVH
`define PBR_REGS_SVH
// ===========================================================================
// Overview of operation
// - A read of the direction register always returns all ones.
// - A direction bit of 0 makes its pin an input, 1 an output from data.
// - A data read returns the synchronised, filtered pin level for each input pin.
// - A data read returns the latched data bit for each output pin.
// - On an input pin the pull-up is on exactly when its data bit is 1.
// - Set and clear read the whole byte, change one bit, write eight back.
// - The write-back overwrites every bit but the modified one with the value that was read.
// - Set, clear, invert and test take the bit number from immediate or reg.
// - Carry logic, load, store and inverted forms accept only an immediate.
// - Operands decode as direct, indirect or absolute, low nibble zero.
// ===========================================================================
`define PBR_OFS_DIR 5'h00
`define PBR_OFS_DATA 5'h04
`define PBR_OFS_OP 5'h08
`define PBR_OFS_STAT 5'h0c
`define PBR_OFS_GREG 5'h10
`define PBR_RST_DIR 8'h00
`define PBR_RST_DATA 8'h00
`define PBR_DIR_READ 8'hff
`define PBR_STAT_BUSY 0
`define PBR_STAT_ILL 1
`define PBR_STAT_CARRY 2
`define PBR_STAT_ZERO 3
`endif

// *** hdl/pbr_pkg.sv ***
package pbr_pkg;
  typedef enum logic [1:0] {
    PBR_T_REG, PBR_T_DIR, PBR_T_DATA, PBR_T_NONE
  } pbr_target_e;
  typedef enum logic [3:0] {
    PBR_OP_SET, PBR_OP_CLR, PBR_OP_NOT, PBR_OP_TST, PBR_OP_AND,
    PBR_OP_OR, PBR_OP_XOR, PBR_OP_LD, PBR_OP_ST, PBR_OP_IAND,
    PBR_OP_IOR, PBR_OP_IXOR, PBR_OP_ILD, PBR_OP_IST, PBR_OP_BAD
  } pbr_op_e;
endpackage : pbr_pkg

// *** hdl/pbr_sync.sv ***
module pbr_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Raw and filtered levels.
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] cleanOut
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, clean_q;
  logic [WIDTH-1:0] clean_d;
  genvar i;
  // The first stage is read only by the second.
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        clean_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : clean_q[i];
      end
    end
  endgenerate
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      clean_q <= '0;
    end else begin
      s1_q <= rawIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
    end
  end
  assign cleanOut = clean_q;
endmodule : pbr_sync

// *** verification/pbr_pin_model.sv ***
module pbr_pin_model (
  // Design side.
  input wire logic clk,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] pullUpOn,
  // Far side drive.
  input wire logic [7:0] extVal,
  input wire logic [7:0] extEn,
  output logic [7:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wobble = 8'h55;
  // A floating pin without pull-up toggles every clock, so the input filter keeps its last settled level.
  always @(posedge clk) wobble <= ~wobble;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extVal[i];
      else if (pullUpOn[i]) pinIn[i] = 1'b1;
      else pinIn[i] = wobble[i];
    end
  end
endmodule : pbr_pin_model

// *** verification/tb_top.sv ***
`include "pbr_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pbr_pkg::*;
  logic clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0;
  logic [4:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] datI = 0, datO, rd;
  logic ack;
  logic [7:0] pinIn, pinOut, pinOe, pullUpOn;
  logic [7:0] extVal = 0, extEn = 8'hff;
  int num_errors = 0, checks_done = 0, cycles = 0;
  port_bit_rmw_access uut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .pullUpOn(pullUpOn));
  pbr_pin_model pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
    .pullUpOn(pullUpOn), .extVal(extVal), .extEn(extEn), .pinIn(pinIn));
  initial begin
    forever #10 clk = ~clk;
  end
  // ==========================================================================
  // Reporting.
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  // ==========================================================================
  // Bus cycles and expectations.
  // Only the bench timeout ends a wait for acknowledge.
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    datI <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = datO;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
    chk("ack", 0, ack);
  endtask : wb
  task automatic cmd(input logic [31:0] w);
    wb(1, `PBR_OFS_OP, w);
    do begin
      wb(0, `PBR_OFS_STAT, 0);
    end while (rd[`PBR_STAT_BUSY] !== 1'b0);
  endtask : cmd
  function automatic logic [31:0] opw(input pbr_op_e c, input logic g,
    input logic [2:0] b, input logic [1:0] m, input logic [7:0] t);
    return {1'b0, m, g, c, 1'b0, b, 4'h0, t, 8'h00};
  endfunction : opw
  function automatic logic [7:0] rdexp(input logic [7:0] dir, dat, pin);
    return (pin & ~dir) | (dat & dir);
  endfunction : rdexp
  function automatic logic [8:0] opexp(input pbr_op_e c,
    input logic [7:0] g, input logic [2:0] b, input logic ci);
    logic [7:0] r;
    logic cy;
    logic v;
    r = g;
    cy = ci;
    v = g[b];
    case (c)
      PBR_OP_SET: r[b] = 1'b1;
      PBR_OP_CLR: r[b] = 1'b0;
      PBR_OP_NOT: r[b] = ~v;
      PBR_OP_AND: cy = ci & v;
      PBR_OP_OR: cy = ci | v;
      PBR_OP_XOR: cy = ci ^ v;
      PBR_OP_LD: cy = v;
      PBR_OP_ST: r[b] = ci;
      PBR_OP_IAND: cy = ci & ~v;
      PBR_OP_IOR: cy = ci | ~v;
      PBR_OP_IXOR: cy = ci ^ ~v;
      PBR_OP_ILD: cy = ~v;
      PBR_OP_IST: r[b] = ~ci;
      default: ;
    endcase
    return {cy, r};
  endfunction : opexp
  // The data read lags the pins by the input synchroniser, hence the wait.
  // A pin left undriven outside always has its data bit set, so an input
  // there is held high by its pull-up rather than floating.
  task automatic setp(input logic [7:0] dir, dat, ext, en);
    logic [7:0] drv;
    drv = en | ~dat;
    wb(1, `PBR_OFS_DIR, {24'h0, dir});
    wb(1, `PBR_OFS_DATA, {24'h0, dat});
    extVal <= ext;
    extEn <= drv;
    repeat (6) @(posedge clk);
    wb(0, `PBR_OFS_DATA, 0);
    chk("data read", rdexp(dir, dat, (ext & drv) | ~drv), rd);
    chk("pin oe", dir, pinOe);
    chk("pin out", dir & dat, pinOut);
    chk("pull-up", ~dir & dat, pullUpOn);
  endtask : setp
  // ==========================================================================
  // Scenarios.
  initial begin
    logic [7:0] g;
    logic [2:0] b;
    logic ci;
    logic [8:0] e;
    void'($urandom(32'h5f8c));
    repeat (5) @(posedge clk);
    reset_n <= 1;
    wb(0, `PBR_OFS_DIR, 0);
    chk("dir read", {24'h0, `PBR_DIR_READ}, rd);
    wb(0, 5'h14, 0);
    chk("unmapped", 0, rd);
    setp(8'h3f, 8'h80, 8'h40, 8'hff);
    cmd(opw(PBR_OP_CLR, 0, 0, 2, 8'h00));
    chk("dir rmw", 8'hfe, pinOe);
    setp(8'h3f, 8'h80, 8'h40, 8'hff);
    cmd(opw(PBR_OP_SET, 0, 0, 2, 8'h01));
    chk("data rmw", 8'h01, pinOut);
    chk("pull-up rmw", 8'h40, pullUpOn);
    wb(1, `PBR_OFS_GREG, 5);
    setp(8'hff, 8'h00, 8'h00, 8'hff);
    cmd(opw(PBR_OP_SET, 1, 0, 2, 8'h01));
    chk("greg bit", 8'h20, pinOut);
    cmd(opw(PBR_OP_LD, 1, 0, 0, 8'h00));
    chk("ill flag", 1, rd[`PBR_STAT_ILL]);
    cmd(opw(PBR_OP_SET, 0, 3, 1, 8'h01) | 1);
    chk("ill flag", 1, rd[`PBR_STAT_ILL]);
    cmd(opw(PBR_OP_SET, 0, 4, 3, 8'h01));
    chk("ill flag", 1, rd[`PBR_STAT_ILL]);
    chk("no exec", 8'h20, pinOut);
    cmd(opw(PBR_OP_NOT, 0, 5, 1, 8'h01));
    chk("indirect", 8'h00, pinOut);
    for (int i = 0; i < 14; i++) begin
      g = 8'($urandom);
      b = 3'($urandom);
      ci = 1'($urandom);
      wb(1, `PBR_OFS_GREG, {24'h0, g});
      wb(1, `PBR_OFS_STAT, {29'h0, ci, 2'h0});
      cmd(opw(pbr_op_e'(i), 0, b, 0, 8'h00));
      e = opexp(pbr_op_e'(i), g, b, ci);
      chk("carry", e[8], rd[`PBR_STAT_CARRY]);
      if (i == 3) chk("zero", {31'h0, ~g[b]}, rd[`PBR_STAT_ZERO]);
      wb(0, `PBR_OFS_GREG, 0);
      chk("greg", e[7:0], rd);
    end
    for (int i = 0; i < 8; i++) begin
      setp(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
    end
    test_done();
  end
endmodule : tb_top
